/* common/crs_pkg.sv */
package crs_pkg;

  // Register offsets on the controller peripheral bus (byte addresses).
  localparam logic [7:0] CRS_OFF_HOST_NEED   = 8'h18;
  localparam logic [7:0] CRS_OFF_CTRL_NEED_A = 8'h1C;
  localparam logic [7:0] CRS_OFF_OSCILLATOR_IDENTITY      = 8'h20;
  localparam logic [7:0] CRS_OFF_TEST_CTRL   = 8'h24;
  localparam logic [7:0] CRS_OFF_CTRL_NEED_B = 8'h34;

  // Implemented bit masks, aligned with the matching sleep-enable layouts.
  localparam logic [31:0] CRS_MASK_HOST   = 32'h0000_0157;
  localparam logic [31:0] CRS_MASK_CTRL_A = 32'h003F_03E7;
  localparam logic [31:0] CRS_MASK_CTRL_B = 32'h0000_3393;

  // Oscillator identity fields; values are arbitrary.
  localparam int          CRS_ID_SHRINK_LSB  = 0;
  localparam int          CRS_ID_FOUNDRY_LSB = 2;
  localparam int          CRS_ID_REV_LSB     = 4;
  localparam logic [1:0]  CRS_ID_SHRINK      = 2'h1;
  localparam logic [1:0]  CRS_ID_FOUNDRY     = 2'h2;
  localparam logic [3:0]  CRS_ID_REVISION    = 4'h3;

  // Test register fields.
  localparam int          CRS_TST_WIDE_TOL_BIT = 0;
  localparam int          CRS_TST_DELAY_LSB    = 1;
  localparam logic [31:0] CRS_TEST_RESET       = 32'h0000_0000;
  localparam logic [31:0] CRS_TEST_MASK        = 32'h0000_001F;

endpackage

/* verilog/crs_status.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - A block that is enabled and needs the core clock reads 1 in its bit.
// - A block that is disabled or has slept and released the clock reads 0.
// - Host and controller blocks have separate registers, sleep-enable layout.
// - The identity register holds a fixed read-only 2-bit shrink factor in bits 1:0.
// - The identity register holds a fixed read-only 2-bit foundry code in bits 3:2.
// - The identity register holds a fixed read-only 4-bit revision in bits 7:4.
// - Test bit 0 selects wide-tolerance mode when 0 and disables it when 1.
// - Test bits 4:1 hold the sleep delay, 0 to 15 processor clocks.
module crs_status
  import crs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // Per-block clock needs from the block clocking logic
  input  wire logic [31:0] host_need,
  input  wire logic [31:0] ctrl_need_a,
  input  wire logic [31:0] ctrl_need_b,
  // Register port
  input  wire logic        reg_sel,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  // Oscillator test controls
  output var  logic        wide_tol_mode,
  output var  logic [3:0]  sleep_delay
);

  typedef struct packed {
    logic [31:0] host;
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] test;
    logic [31:0] rdata;
    logic        wide_tol;
    logic [3:0]  delay;
  } crs_state_t;

  crs_state_t       st;
  crs_state_t       next_st;

  // Access decode.
  logic             acc_rd;
  logic             acc_wr;
  logic             test_wr;

  // Status words with every reserved position forced low.
  wire logic [31:0] host_masked;
  wire logic [31:0] ctrl_a_masked;
  wire logic [31:0] ctrl_b_masked;

  // Fixed identity word, the test word to keep and the selected read word.
  logic [31:0]      id_word;
  logic [31:0]      test_word;
  logic [31:0]      read_word;
  logic             wide_tol_next;
  logic [3:0]       delay_next;

  // Host status positions, one block to a bit.
  // Bit 0 is embedded_mem_iface.
  // Bit 1 is the host bus interface.
  // Bit 2 is the first serial port.
  // Bit 4 is the flash serial interface.
  // Bit 6 is the second serial port.
  // Bit 8 is the runtime register logic.
  // Controller status A positions.
  // Bit 0 is counter_timer_first.
  // Bit 1 is counter_timer_second.
  // Bit 2 is counter_timer_third.
  // Bit 5 is serial_debug_port.
  // Bit 6 is fan_speed_in_first.
  // Bit 7 is fan_speed_in_second.
  // Bit 8 is fan_speed_in_third.
  // Bit 9 is link_master_ctrl.
  // Bits 16 to 19 are fan drives one to four.
  // Bit 20 is sys_bus_ctrl_first.
  // Bit 21 is sys_bus_ctrl_second.
  // Controller status B positions.
  // Bits 0 and 1 are fan drives five and six.
  // Bit 4 is the fourth fan speed input.
  // Bit 7 is the DMA engine.
  // Bit 8 is the analog monitor.
  // Bit 9 is the PECI interface.
  // Bit 12 is cpu_hot_monitor.
  // Bit 13 is the one-time programmable memory.
  // Every position not listed is reserved and must read 0.

  // A bit survives only where a block sits in the matching sleep-enable
  // register, so a stray need line can never show up in a reserved bit.
  for (genvar b = 0; b < 32; b++) begin : g_need
    assign host_masked[b]   = host_need[b] & CRS_MASK_HOST[b];
    assign ctrl_a_masked[b] = ctrl_need_a[b] & CRS_MASK_CTRL_A[b];
    assign ctrl_b_masked[b] = ctrl_need_b[b] & CRS_MASK_CTRL_B[b];
  end

  always_comb begin
    acc_rd  = reg_sel && !reg_wr;
    acc_wr  = reg_sel && reg_wr;
    // Only the test register takes writes; all others drop them.
    test_wr = acc_wr && (reg_addr == CRS_OFF_TEST_CTRL);
  end

  always_comb begin
    id_word = 32'h0000_0000;
    id_word[CRS_ID_SHRINK_LSB +: 2]  = CRS_ID_SHRINK;
    id_word[CRS_ID_FOUNDRY_LSB +: 2] = CRS_ID_FOUNDRY;
    id_word[CRS_ID_REV_LSB +: 4]     = CRS_ID_REVISION;
  end

  always_comb begin
    test_word = st.test;
    if (test_wr) begin
      // Bits above the delay field are reserved and never stored.
      test_word = reg_wdata & CRS_TEST_MASK;
    end
  end

  always_comb begin
    // Active-low select: a written 0 turns the test mode on.
    wide_tol_next = ~test_word[CRS_TST_WIDE_TOL_BIT];
    delay_next    = test_word[CRS_TST_DELAY_LSB +: 4];
  end

  always_comb begin
    read_word = 32'h0000_0000;
    if (acc_rd) begin
      case (reg_addr)
        CRS_OFF_HOST_NEED: begin
          read_word = st.host;
        end
        CRS_OFF_CTRL_NEED_A: begin
          read_word = st.ctrl_a;
        end
        CRS_OFF_CTRL_NEED_B: begin
          read_word = st.ctrl_b;
        end
        CRS_OFF_OSCILLATOR_IDENTITY: begin
          read_word = id_word;
        end
        CRS_OFF_TEST_CTRL: begin
          read_word = st.test;
        end
        default: begin
          read_word = 32'h0000_0000;
        end
      endcase
    end
  end

  always_comb begin
    next_st = st;
    // Status lags the need lines by one cycle, which keeps the raw inputs
    // out of the read path at the cost of one cycle of staleness.
    next_st.host     = host_masked;
    next_st.ctrl_a   = ctrl_a_masked;
    next_st.ctrl_b   = ctrl_b_masked;
    next_st.test     = test_word;
    next_st.wide_tol = wide_tol_next;
    next_st.delay    = delay_next;
    next_st.rdata    = read_word;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st.host     <= 32'h0000_0000;
      st.ctrl_a   <= 32'h0000_0000;
      st.ctrl_b   <= 32'h0000_0000;
      st.test     <= CRS_TEST_RESET;
      st.rdata    <= 32'h0000_0000;
      st.wide_tol <= ~CRS_TEST_RESET[CRS_TST_WIDE_TOL_BIT];
      st.delay    <= CRS_TEST_RESET[CRS_TST_DELAY_LSB +: 4];
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata     = st.rdata;
  assign wide_tol_mode = st.wide_tol;
  assign sleep_delay   = st.delay;

endmodule
`default_nettype wire

/* test/crs_status_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module crs_status_properties
  import crs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        reg_sel,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] host_need,
  input wire logic [31:0] ctrl_need_a,
  input wire logic [31:0] ctrl_need_b,
  input wire logic [31:0] reg_rdata,
  input wire logic        wide_tol_mode,
  input wire logic [3:0]  sleep_delay
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  wire logic rd = reg_sel && !reg_wr;
  wire logic wt = reg_sel && reg_wr && reg_addr == CRS_OFF_TEST_CTRL;
  wire logic [31:0] id_exp = {24'h00_0000, CRS_ID_REVISION, CRS_ID_FOUNDRY,
                              CRS_ID_SHRINK};
  sequence s_read(logic [7:0] addr);
    rd && reg_addr == addr;
  endsequence
  // Status reads only make sense once the previous cycle was out of reset.
  sequence s_status_read(logic [7:0] addr);
    !$past(srst) ##0 s_read(addr);
  endsequence
  sequence s_test_write;
    wt;
  endsequence
  property p_id;
    s_read(CRS_OFF_OSCILLATOR_IDENTITY) |=> reg_rdata == id_exp;
  endproperty
  property p_host;
    s_status_read(CRS_OFF_HOST_NEED) |=>
      reg_rdata == ($past(host_need, 2) & CRS_MASK_HOST);
  endproperty
  property p_ctrl_a;
    s_status_read(CRS_OFF_CTRL_NEED_A) |=>
      reg_rdata == ($past(ctrl_need_a, 2) & CRS_MASK_CTRL_A);
  endproperty
  property p_ctrl_b;
    s_status_read(CRS_OFF_CTRL_NEED_B) |=>
      reg_rdata == ($past(ctrl_need_b, 2) & CRS_MASK_CTRL_B);
  endproperty
  property p_test_wr;
    s_test_write |=> {sleep_delay, !wide_tol_mode} == $past(reg_wdata[4:0]);
  endproperty
  property p_test_rd;
    s_read(CRS_OFF_TEST_CTRL) |=>
      reg_rdata == {27'h000_0000, $past(sleep_delay), !$past(wide_tol_mode)};
  endproperty
  property p_test_hold;
    !wt |=> $stable({sleep_delay, wide_tol_mode});
  endproperty
  property p_idle;
    !rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_id: assert property (p_id)
    else $error("identity word wrong");
  a_host: assert property (p_host)
    else $error("host status wrong");
  a_ctrl_a: assert property (p_ctrl_a)
    else $error("controller status A wrong");
  a_ctrl_b: assert property (p_ctrl_b)
    else $error("controller status B wrong");
  a_test_wr: assert property (p_test_wr)
    else $error("test write wrong");
  a_test_rd: assert property (p_test_rd)
    else $error("test read wrong");
  a_test_hold: assert property (p_test_hold)
    else $error("test outputs moved");
  a_idle: assert property (p_idle)
    else $error("read data not idle");
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crs_pkg::*;
  logic ref_clk = 0, srst = 1, reg_sel = 0, reg_wr = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] host_need = 0, reg_wdata = 0, reg_rdata;
  logic wide_tol_mode;
  logic [3:0] sleep_delay;
  int mismatches = 0, compares = 0;
  crs_status dut_u (.*, .ctrl_need_a(~host_need), .ctrl_need_b(host_need));
  initial forever #2 ref_clk = ~ref_clk;
  task chk(string n, logic [31:0] s, e);
    compares++;
    if (s !== e) $display("ERROR %s exp %h seen %h", n, e, s);
    mismatches += s !== e;
  endtask
  task acc(logic w, logic [7:0] a, logic [31:0] d, e);
    @(negedge ref_clk);
    {reg_sel, reg_wr, reg_addr, reg_wdata} = {1'h1, w, a, d};
    @(negedge ref_clk);
    reg_sel = 1'h0;
    chk("reg_rdata", reg_rdata, e);
  endtask
  task t_regs;
    logic [7:0] idw;
    idw = {CRS_ID_REVISION, CRS_ID_FOUNDRY, CRS_ID_SHRINK};
    chk("wide_tol_mode", wide_tol_mode, 1);
    chk("sleep_delay", sleep_delay, 0);
    acc(1, 8'h20, '1, 0);
    acc(0, 8'h20, 0, idw);
    acc(1, 8'h24, '1, 0);
    chk("wide_tol_mode", wide_tol_mode, 0);
    chk("sleep_delay", sleep_delay, 32'hF);
    acc(1, 8'h24, 32'hFFFFFFF4, 0);
    chk("wide_tol_mode", wide_tol_mode, 1);
    chk("sleep_delay", sleep_delay, 32'hA);
    acc(0, 8'h24, 0, 32'h14);
    acc(0, 8'h28, 0, 0);
  endtask
  task t_need(logic [31:0] v);
    host_need = v;
    acc(0, 8'h18, 0, v & CRS_MASK_HOST);
    acc(0, 8'h1C, 0, ~v & CRS_MASK_CTRL_A);
    acc(0, 8'h34, 0, v & CRS_MASK_CTRL_B);
  endtask
  task conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge ref_clk);
    srst = 0;
    t_regs;
    t_need('1);
    t_need(0);
    conclude;
  end
endmodule
bind crs_status crs_status_properties chk_u (.*);
`default_nettype wire
